// File: rtl/msc_cfg.svh
/*
  Offsets, field positions, encodings, reset values and timing counts
  for the multi-unit sync chain. Assumes inclusion by its bare name.
*/
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define MSC_ADDR_W        8
`define MSC_OFF_CONFIG    8'h00
`define MSC_OFF_TRIG      8'h04
`define MSC_OFF_CMD       8'h08
`define MSC_OFF_STATUS    8'h0c
`define MSC_OFF_IRQ_STAT  8'h10
`define MSC_OFF_IRQ_MASK  8'h14
`define MSC_OFF_PLAY      8'h18

// Role field encodings
`define MSC_ROLE_OFF      2'h0
`define MSC_ROLE_MASTER   2'h1
`define MSC_ROLE_SLAVE    2'h2

// Trigger type encodings
`define MSC_TT_FREE       2'h0
`define MSC_TT_SINGLE     2'h1
`define MSC_TT_RETRIG     2'h2
`define MSC_TT_GATED      2'h3

// Trigger source encodings
`define MSC_TS_EXT        2'h0
`define MSC_TS_KEY        2'h1
`define MSC_TS_BUS        2'h2
`define MSC_TS_CHAIN      2'h3

// Command bits
`define MSC_CMD_LISTEN    0
`define MSC_CMD_SYNC      1
`define MSC_CMD_BUSTRIG   2

// Interrupt bits
`define MSC_IRQ_CONFLICT  0
`define MSC_IRQ_INSYNC    1
`define MSC_IRQ_START     2

// Reset values
`define MSC_RST_ROLE      2'h0
`define MSC_RST_NSLV      4'h0
`define MSC_RST_POS       4'h1
`define MSC_RST_TTYPE     2'h0
`define MSC_RST_TSRC      2'h0
`define MSC_RST_MASK      3'h0

// Timing
`define MSC_CLK_PERIOD_NS 40
`define MSC_SKEW_NS       8
`define MSC_HOP_CYC       4
`define MSC_MAX_UNITS     16

`endif

// File: rtl/msc_pkg.sv
/*
  Types of the multi-unit sync chain.
  Assumes msc_cfg.svh carries all numeric constants.
*/
package msc_pkg;
  // Reported synchronization state of a unit
  typedef enum logic [1:0] {
    MSC_ST_UNSYNCED,
    MSC_ST_WAITING,
    MSC_ST_IN_SYNC
  } msc_sync_type;
endpackage : msc_pkg

// File: rtl/msc_sync_chain.sv
/*
  Multi-unit sync chain: one unit of a daisy chain of waveform players,
  with its AXI4-Lite register slave, trigger restrictions, sync state and
  playback start alignment.
  Assumes the event output feeds the next unit's chain input, and that
  all pins are asynchronous to clk.
*/
//
// Overview of operation
// [RQ1] Up to 16 units, starts aligned per hop
// [RQ2] Each cable hop adds under 1 ns
// [RQ3] Master emits one pulse through all slaves
// [RQ4] Slave accepts pulse only while armed
// [RQ5] Software stops triggers and players before sync
// [RQ6] No slave feedback, no automatic resync
// [RQ7] Armed slave takes any chain pulse as sync
// [RQ8] Player and trigger edits keep sync state
// [RQ9] Slave source fixed to chain input
// [RQ10] Master selects external, key or bus trigger
// [RQ11] Unsupported trigger settings forced, error raised
// [RQ12] Triggers follow the sync pulse path
// [RQ13] Role off keeps trigger; free run plays
// [RQ14] Slave count and position, fifteen slaves
// [RQ15] Listen arms slave, reports waiting
// [RQ16] Sync command puts chain in sync
// [RQ17] Config change reports status_unsynced
// [RQ18] Missing cable goes undetected
// [RQ19] Status register: unsynced, waiting, in sync
`timescale 1ns/1ps
`include "msc_cfg.svh"

module msc_sync_chain
  import msc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`MSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`MSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   chain_trigger_input,
  input  wire logic                   ext_trigger_in,
  input  wire logic                   trig_key_in,
  output logic                        event_out,
  output logic                        play_run,
  output logic                        play_start,
  output logic                        settings_conflict,
  output logic                        status_unsynced,
  output logic                        irq
);

  localparam int MAX_DLY  = (`MSC_MAX_UNITS - 1) * `MSC_HOP_CYC;

  logic [2:0]             pin_in;
  logic [2:0]             pin_s1_q;
  logic [2:0]             pin_s2_q;
  logic [2:0]             pin_s3_q;
  logic [2:0]             pin_lvl_q;
  logic [2:0]             pin_rise;
  logic                   chain_rise;
  logic                   aw_have_q;
  logic [`MSC_ADDR_W-1:0] aw_addr_q;
  logic                   w_have_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;
  logic                   awready_q;
  logic                   wready_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   arready_q;
  logic                   rvalid_q;
  logic                   rvalid_d;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;
  logic                   wr_fire;
  logic                   ar_hs;
  logic                   wr_cfg;
  logic                   wr_trig;
  logic                   wr_cmd;
  logic                   wr_mask;
  logic                   wr_play;
  logic                   wr_err;
  logic [31:0]            rd_data;
  logic                   rd_err;
  logic                   rd_clr;
  logic [1:0]             role_q;
  logic [3:0]             nslv_q;
  logic [3:0]             pos_q;
  logic [1:0]             ttype_q;
  logic [1:0]             tsrc_q;
  logic                   play_on_q;
  logic [2:0]             mask_q;
  logic [2:0]             stat_q;
  logic [2:0]             stat_ev;
  msc_sync_type           state_q;
  logic [1:0]             role_d;
  logic [1:0]             ttype_c;
  logic [1:0]             tsrc_c;
  logic [1:0]             ttype_f;
  logic [1:0]             tsrc_f;
  logic                   apply;
  logic                   bad;
  logic                   is_master;
  logic                   is_slave;
  logic                   cmd_listen;
  logic                   cmd_sync;
  logic                   cmd_bus;
  logic                   src_evt;
  logic                   trig_ok;
  logic [3:0]             hops;
  logic [6:0]             dly_cyc;
  logic [6:0]             dly_q;
  logic                   dly_act_q;
  logic                   start_now;
  logic                   event_out_q;
  logic                   play_run_q;
  logic                   play_start_q;
  logic                   conflict_q;
  logic                   unsynced_q;
  logic                   irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, an edge counts once stages 2 and 3 agree
  assign pin_in = {trig_key_in, ext_trigger_in, chain_trigger_input};

  genvar g;
  for (g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge clk) begin
      if (reset) begin
        pin_s1_q[g]  <= 1'b0;
        pin_s2_q[g]  <= 1'b0;
        pin_s3_q[g]  <= 1'b0;
        pin_lvl_q[g] <= 1'b0;
      end else begin
        pin_s1_q[g] <= pin_in[g];
        pin_s2_q[g] <= pin_s1_q[g];
        pin_s3_q[g] <= pin_s2_q[g];
        if (pin_s2_q[g] == pin_s3_q[g]) begin
          pin_lvl_q[g] <= pin_s3_q[g];
        end
      end
    end
    assign pin_rise[g] = (pin_s2_q[g] == pin_s3_q[g]) && pin_s3_q[g] && !pin_lvl_q[g];
  end

  // No carrier detect on the chain input: a dead link simply never pulses
  assign chain_rise = pin_rise[0]; // [RQ18]

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data held independently
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign ar_hs   = s_axi_arvalid && arready_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      awready_q <= 1'b0;
    end else begin
      awready_q <= wr_fire || (!aw_have_q && !(s_axi_awvalid && awready_q));
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      wready_q <= 1'b0;
    end else begin
      wready_q <= wr_fire || (!w_have_q && !(s_axi_wvalid && wready_q));
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write decode; unmapped offsets answer SLVERR and change nothing
  always_comb begin
    wr_cfg  = 1'b0;
    wr_trig = 1'b0;
    wr_cmd  = 1'b0;
    wr_mask = 1'b0;
    wr_play = 1'b0;
    wr_err  = 1'b0;
    if (!wr_fire) begin
      wr_err = 1'b0;
    end else if (aw_addr_q == `MSC_OFF_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (aw_addr_q == `MSC_OFF_TRIG) begin
      wr_trig = 1'b1;
    end else if (aw_addr_q == `MSC_OFF_CMD) begin
      wr_cmd = 1'b1;
    end else if (aw_addr_q == `MSC_OFF_IRQ_MASK) begin
      wr_mask = 1'b1;
    end else if (aw_addr_q == `MSC_OFF_PLAY) begin
      wr_play = 1'b1;
    end else if (aw_addr_q == `MSC_OFF_STATUS || aw_addr_q == `MSC_OFF_IRQ_STAT) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration: role, slave count and own chain position
  assign role_d = (wr_cfg && w_strb_q[0]) ? w_data_q[1:0] : role_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      role_q <= `MSC_RST_ROLE;
      nslv_q <= `MSC_RST_NSLV;
      pos_q  <= `MSC_RST_POS;
    end else if (wr_cfg) begin
      if (w_strb_q[0]) begin
        role_q <= w_data_q[1:0];
        nslv_q <= w_data_q[7:4]; // [RQ14] four bits cap at fifteen slaves
      end
      if (w_strb_q[1]) begin
        pos_q <= w_data_q[11:8]; // [RQ14]
      end
    end
  end

  assign is_master = (role_q == `MSC_ROLE_MASTER);
  assign is_slave  = (role_q == `MSC_ROLE_SLAVE);

  // Trigger restrictions are re-checked whenever role or trigger is written
  assign apply   = wr_cfg || wr_trig;
  assign ttype_c = (wr_trig && w_strb_q[0]) ? w_data_q[1:0] : ttype_q;
  assign tsrc_c  = (wr_trig && w_strb_q[0]) ? w_data_q[5:4] : tsrc_q;

  always_comb begin
    ttype_f = ttype_c;
    tsrc_f  = tsrc_c;
    bad     = 1'b0;
    if (role_d == `MSC_ROLE_MASTER || role_d == `MSC_ROLE_SLAVE) begin
      if (ttype_c == `MSC_TT_GATED) begin
        ttype_f = `MSC_TT_SINGLE; // [RQ11]
        bad     = 1'b1;
      end
    end
    if (role_d == `MSC_ROLE_SLAVE && tsrc_c != `MSC_TS_CHAIN) begin
      tsrc_f = `MSC_TS_CHAIN; // [RQ9] [RQ11]
      bad    = 1'b1;
    end else if (role_d == `MSC_ROLE_MASTER && tsrc_c == `MSC_TS_CHAIN) begin
      tsrc_f = `MSC_TS_EXT; // [RQ10] [RQ11]
      bad    = 1'b1;
    end
  end

  // Leaving sync mode keeps whatever trigger was forced last
  always_ff @(posedge clk) begin
    if (reset) begin
      ttype_q <= `MSC_RST_TTYPE;
      tsrc_q  <= `MSC_RST_TSRC;
    end else if (apply) begin
      ttype_q <= ttype_f; // [RQ13]
      tsrc_q  <= tsrc_f;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      play_on_q <= 1'b0;
      mask_q    <= `MSC_RST_MASK;
    end else begin
      if (wr_play && w_strb_q[0]) begin
        play_on_q <= w_data_q[0];
      end
      if (wr_mask && w_strb_q[0]) begin
        mask_q <= w_data_q[2:0];
      end
    end
  end

  assign cmd_listen = wr_cmd && w_strb_q[0] && w_data_q[`MSC_CMD_LISTEN];
  assign cmd_sync   = wr_cmd && w_strb_q[0] && w_data_q[`MSC_CMD_SYNC];
  assign cmd_bus    = wr_cmd && w_strb_q[0] && w_data_q[`MSC_CMD_BUSTRIG];

  ////////////////////////////////////////////////////////////////////////
  // Sync state; only config writes, listen, sync commands and chain pulses move it [RQ8] [RQ19]
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= MSC_ST_UNSYNCED;
    end else if (wr_cfg) begin
      state_q <= MSC_ST_UNSYNCED; // [RQ17]
    end else begin
      case (state_q)
        MSC_ST_UNSYNCED: begin
          if (is_slave && cmd_listen) begin
            state_q <= MSC_ST_WAITING; // [RQ15]
          end else if (is_master && cmd_sync) begin
            state_q <= MSC_ST_IN_SYNC; // [RQ16] [RQ6]
          end
        end
        MSC_ST_WAITING: begin
          if (is_slave && cmd_listen) begin
            state_q <= MSC_ST_WAITING; // [RQ15]
          end else if (is_slave && chain_rise) begin
            state_q <= MSC_ST_IN_SYNC; // [RQ4] [RQ7]
          end
        end
        default: begin
          // Stale in-sync stays until software reconfigures or a slave gets listen
          if (is_slave && cmd_listen) begin
            state_q <= MSC_ST_WAITING; // [RQ15]
          end else if (is_master && cmd_sync) begin
            state_q <= MSC_ST_IN_SYNC; // [RQ6]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger events and the chain output
  always_comb begin
    case (tsrc_q)
      `MSC_TS_EXT: src_evt = pin_rise[1];
      `MSC_TS_KEY: src_evt = pin_rise[2];
      `MSC_TS_BUS: src_evt = cmd_bus;
      default:     src_evt = chain_rise;
    endcase
  end

  // A slave's own trigger is a chain edge that does not complete arming
  assign trig_ok = play_on_q && (ttype_q != `MSC_TT_FREE) &&
                   (is_slave ? (chain_rise && state_q == MSC_ST_IN_SYNC) : src_evt);

  // Master sends sync and triggers; slave repeats every chain edge
  always_ff @(posedge clk) begin
    if (reset) begin
      event_out_q <= 1'b0;
    end else if (is_master) begin
      event_out_q <= cmd_sync || src_evt; // [RQ3] [RQ12]
    end else if (is_slave) begin
      event_out_q <= chain_rise; // [RQ3] [RQ12]
    end else begin
      event_out_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start alignment: wait out the hops still ahead of the trigger
  always_comb begin
    if (is_master) begin
      hops = nslv_q;
    end else if (is_slave && nslv_q > pos_q) begin
      hops = nslv_q - pos_q;
    end else begin
      hops = 4'h0;
    end
  end

  assign dly_cyc   = 7'({3'h0, hops} * 7'(`MSC_HOP_CYC)); // [RQ1]
  assign start_now = dly_act_q && (dly_q == 7'h00);

  always_ff @(posedge clk) begin
    if (reset) begin
      dly_act_q <= 1'b0;
      dly_q     <= 7'h00;
    end else if (!play_on_q) begin
      dly_act_q <= 1'b0;
    end else if (dly_act_q) begin
      dly_act_q <= (dly_q != 7'h00);
      dly_q     <= dly_q - 7'h01;
    end else if (trig_ok) begin
      dly_act_q <= 1'b1; // [RQ1]
      dly_q     <= dly_cyc;
    end
  end

  // Free run plays without any trigger once the player is on
  always_ff @(posedge clk) begin
    if (reset) begin
      play_run_q   <= 1'b0;
      play_start_q <= 1'b0;
    end else if (!play_on_q) begin
      play_run_q   <= 1'b0;
      play_start_q <= 1'b0;
    end else begin
      play_start_q <= start_now || (ttype_q == `MSC_TT_FREE && !play_run_q);
      if (ttype_q == `MSC_TT_FREE || start_now) begin
        play_run_q <= 1'b1; // [RQ13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, cleared by a read; a same-cycle event survives the read
  assign stat_ev[`MSC_IRQ_CONFLICT] = apply && bad;
  assign stat_ev[`MSC_IRQ_INSYNC]   = (state_q != MSC_ST_IN_SYNC) && !wr_cfg &&
                                      ((is_slave && chain_rise && state_q == MSC_ST_WAITING
                                        && !cmd_listen) || (is_master && cmd_sync));
  assign stat_ev[`MSC_IRQ_START]    = play_on_q && start_now;
  assign rd_clr = ar_hs && (s_axi_araddr == `MSC_OFF_IRQ_STAT);

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_q     <= 3'h0;
      conflict_q <= 1'b0;
      unsynced_q <= 1'b1;
      irq_q      <= 1'b0;
    end else begin
      stat_q     <= (rd_clr ? 3'h0 : stat_q) | stat_ev;
      conflict_q <= stat_ev[`MSC_IRQ_CONFLICT]; // [RQ11]
      unsynced_q <= (state_q == MSC_ST_UNSYNCED);
      irq_q      <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (s_axi_araddr == `MSC_OFF_CONFIG) begin
      rd_data = {20'h0, pos_q, nslv_q, 2'h0, role_q};
    end else if (s_axi_araddr == `MSC_OFF_TRIG) begin
      rd_data = {26'h0, tsrc_q, 2'h0, ttype_q};
    end else if (s_axi_araddr == `MSC_OFF_CMD) begin
      rd_data = 32'h0;
    end else if (s_axi_araddr == `MSC_OFF_STATUS) begin
      rd_data = {26'h0, play_run_q, dly_act_q, role_q, state_q};
    end else if (s_axi_araddr == `MSC_OFF_IRQ_STAT) begin
      rd_data = {29'h0, stat_q};
    end else if (s_axi_araddr == `MSC_OFF_IRQ_MASK) begin
      rd_data = {29'h0, mask_q};
    end else if (s_axi_araddr == `MSC_OFF_PLAY) begin
      rd_data = {31'h0, play_on_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  assign rvalid_d = ar_hs || (rvalid_q && !s_axi_rready);

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else begin
      rvalid_q  <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_data;
        rresp_q <= rd_err ? 2'h2 : 2'h0;
      end
    end
  end

  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign event_out         = event_out_q;
  assign play_run          = play_run_q;
  assign play_start        = play_start_q;
  assign settings_conflict = conflict_q;
  assign status_unsynced   = unsynced_q;
  assign irq               = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CFG_UNSYNC: assert property (@(posedge clk) disable iff (reset) // [RQ17]
    wr_cfg |=> state_q == MSC_ST_UNSYNCED ##1 status_unsynced)
    else $error("config write left sync state");
  AST_LISTEN: assert property (@(posedge clk) disable iff (reset) // [RQ15]
    is_slave && cmd_listen && !wr_cfg |=> state_q == MSC_ST_WAITING)
    else $error("listen did not arm slave");
  AST_ARMED_ONLY: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    state_q == MSC_ST_UNSYNCED && !cmd_sync |=> state_q != MSC_ST_IN_SYNC)
    else $error("unarmed unit went in sync");
  AST_ANY_PULSE: assert property (@(posedge clk) disable iff (reset) // [RQ7]
    is_slave && state_q == MSC_ST_WAITING && chain_rise && !wr_cfg && !cmd_listen
    |=> state_q == MSC_ST_IN_SYNC && stat_q[`MSC_IRQ_INSYNC])
    else $error("armed slave missed pulse");
  AST_MASTER_PULSE: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    is_master && cmd_sync |=> event_out && state_q == MSC_ST_IN_SYNC)
    else $error("master sent no sync pulse");
  AST_FORWARD: assert property (@(posedge clk) disable iff (reset) // [RQ12]
    is_slave && chain_rise |=> event_out ##1 !event_out || $past(chain_rise))
    else $error("slave did not forward edge");
  AST_SLAVE_SRC: assert property (@(posedge clk) disable iff (reset) // [RQ9]
    is_slave |-> tsrc_q == `MSC_TS_CHAIN)
    else $error("slave source not chain");
  AST_MASTER_SRC: assert property (@(posedge clk) disable iff (reset) // [RQ10]
    is_master |-> tsrc_q != `MSC_TS_CHAIN && ttype_q != `MSC_TT_GATED)
    else $error("master trigger unsupported");
  AST_CONFLICT: assert property (@(posedge clk) disable iff (reset) // [RQ11]
    apply && bad |=> settings_conflict && stat_q[`MSC_IRQ_CONFLICT])
    else $error("conflict not flagged");
  AST_KEEP_SYNC: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    (wr_play || wr_trig || wr_mask) && !chain_rise |=> $stable(state_q))
    else $error("player edit moved sync state");
  AST_ALIGN: assert property (@(posedge clk) disable iff (reset) // [RQ1]
    start_now && play_on_q |=> play_start && play_run)
    else $error("aligned start missed");
  AST_DLY_STEP: assert property (@(posedge clk) disable iff (reset) // [RQ1]
    dly_act_q && dly_q != 7'h00 && play_on_q
    |=> dly_act_q && dly_q == $past(dly_q) - 7'h01 && dly_q < 7'(MAX_DLY))
    else $error("start delay did not count down");

endmodule : msc_sync_chain

// File: sim/msc_peer_model.sv
/* Upstream peer unit that drives one chain link into the unit under test.
   Assumes the shared clk; the cable is modelled with no delay. */
`timescale 1ns/1ps
module msc_peer_model (
  input  wire logic clk,
  input  wire logic send,
  output logic      chain_out
);
  logic [2:0] hold_q = 3'h0;
  // One pulse per request, four cycles long so the far filter sees it
  always @(posedge clk) begin
    if (send) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  // Zero-delay cable, inside the compensated budget
  assign chain_out = (hold_q != 3'h0);
endmodule : msc_peer_model

// File: sim/multi_unit_sync_chain_test.sv
/* Self-checking bench for one sync chain unit, fed by a peer model.
   Assumes msc_cfg.svh offsets; ext and key pins stay low. */
`timescale 1ns/1ps
`include "msc_cfg.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
`define WT(s) begin n = 0; do @(posedge clk); while (s !== 1'b1 && ++n < 100); \
  if (n >= 100) begin num_errors++; end_sim; end end
module multi_unit_sync_chain_test;
  logic        clk = 1'b0, reset = 1'b1, send = 1'b0, ext_trigger_in = 1'b0, trig_key_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        chain_trigger_input, event_out, play_run, play_start, settings_conflict;
  logic        status_unsynced, irq;
  int          num_errors = 0, checks_done = 0, n_ev = 0, n_conf = 0, n, cnt;

  always #20 clk = ~clk;

  msc_sync_chain msc_sync_chain_i (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chain_trigger_input, .ext_trigger_in, .trig_key_in,
    .event_out, .play_run, .play_start, .settings_conflict, .status_unsynced, .irq);
  msc_peer_model msc_peer_model_i (.clk, .send, .chain_out(chain_trigger_input));

  // Count one-cycle pulses; they would be missed by polling between bus cycles
  always @(posedge clk) begin
    if (event_out === 1'b1) n_ev++;
    if (settings_conflict === 1'b1) n_conf++;
  end

  task end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Address and data go out together; each is dropped as soon as it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta = 1'b0, tw = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; n = 0;
    while (!(ta && tw) && n < 100) begin
      @(posedge clk); n++;
      if (s_axi_awready && !ta) begin ta = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !tw) begin tw = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    if (!(ta && tw)) begin num_errors++; end_sim; end
    `WT(s_axi_bvalid)
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
    `WT(s_axi_arready)
    s_axi_arvalid <= 1'b0;
    `WT(s_axi_rvalid)
    rd_q = s_axi_rdata; rsp = s_axi_rresp;
  endtask : rd

  task automatic chk_st(input logic [1:0] e);
    rd(`MSC_OFF_STATUS);
    `CHK("state", e, rd_q[1:0])
  endtask : chk_st

  task pulse;
    send <= 1'b1; @(posedge clk); send <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse

  // Players and triggers stay off until the chain is in sync
  initial begin
    void'($urandom(36378));
    cnt = $urandom_range(15, 1);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("unsynced", 1'b1, status_unsynced)
    rd(8'h40);
    `CHK("rresp", 2'h2, rsp)
    `CHK("rdata", 32'h0, rd_q)
    wr(`MSC_OFF_IRQ_MASK, 32'h7);
    wr(`MSC_OFF_CONFIG, 32'h102 | (cnt << 4));
    wr(`MSC_OFF_TRIG, 32'h3);
    rd(`MSC_OFF_TRIG);
    `CHK("trig", 32'h31, rd_q)
    `CHK("conflict", 2, n_conf)
    pulse;
    `CHK("fwd", 1, n_ev)
    chk_st(2'h0);
    wr(`MSC_OFF_CMD, 32'h1);
    chk_st(2'h1);
    pulse;
    chk_st(2'h2);
    wr(`MSC_OFF_PLAY, 32'h1);
    wr(`MSC_OFF_PLAY, 32'h0);
    chk_st(2'h2);
    `CHK("irq", 1'b1, irq)
    rd(`MSC_OFF_IRQ_STAT);
    `CHK("istat", 32'h3, rd_q)
    rd(`MSC_OFF_IRQ_STAT);
    `CHK("iclr", 32'h0, rd_q)
    `CHK("irq", 1'b0, irq)
    wr(`MSC_OFF_CONFIG, 32'h101 | (cnt << 4));
    chk_st(2'h0);
    `CHK("unsynced", 1'b1, status_unsynced)
    wr(`MSC_OFF_TRIG, 32'h33);
    rd(`MSC_OFF_TRIG);
    `CHK("trig", 32'h01, rd_q)
    `CHK("conflict", 4, n_conf)
    wr(`MSC_OFF_TRIG, 32'h21);
    wr(`MSC_OFF_CMD, 32'h2);
    repeat (2) @(posedge clk);
    `CHK("sync", 3, n_ev)
    chk_st(2'h2);
    wr(`MSC_OFF_PLAY, 32'h1);
    wr(`MSC_OFF_CMD, 32'h4);
    `WT(play_start)
    `CHK("align", cnt * `MSC_HOP_CYC, n)
    @(posedge clk);
    `CHK("run", 1'b1, play_run)
    `CHK("trigfwd", 4, n_ev)
    end_sim;
  end
endmodule : multi_unit_sync_chain_test
